// ---- bench/sep_props.sv ----
// checker for the eeprom protection block ports
`timescale 1ns/1ns
module sep_props #(
    parameter int TWC_CYCLES = 20
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic HOLD_N,
    input wire logic WP_N,
    input wire sep_pkg::sep_nv_s NV_LOAD_BITS,
    input wire logic SO,
    input wire logic SO_OE,
    input wire logic [7:0] STATUS_BYTE,
    input wire logic HW_PROTECT,
    input wire logic ARRAY_WR_STB,
    input wire logic [sep_pkg::ADDR_W-1:0] ARRAY_WR_ADDR,
    input wire logic [7:0] ARRAY_WR_LEN,
    input wire logic NV_STORE_STB,
    input wire sep_pkg::sep_nv_s NV_STORE_BITS
);
    logic [31:0] busy_cnt_r;
    logic qtr_locked;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // length of the current busy stretch, bounds the write cycle
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            busy_cnt_r <= 32'h0;
        end else if (STATUS_BYTE[0]) begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end else begin
            busy_cnt_r <= 32'h0;
        end
    end
    // protected quarter from the shown bits, kept apart from the design helper
    assign qtr_locked = (STATUS_BYTE[3:2] == 2'h3) || (STATUS_BYTE[3:2] == 2'h2 && ARRAY_WR_ADDR[14])
        || (STATUS_BYTE[3:2] == 2'h1 && ARRAY_WR_ADDR[14:13] == 2'h3);
    sequence s_settled;
        !STATUS_BYTE[1] && !STATUS_BYTE[0];
    endsequence
    sequence s_shown;
        STATUS_BYTE[7] == NV_STORE_BITS.pin_en && STATUS_BYTE[3:2] == NV_STORE_BITS.bp;
    endsequence
    a_oe_pause: assert property (!HOLD_N |-> !SO_OE) else $error("output on while paused");
    a_oe_desel: assert property (CS_N |-> !SO_OE) else $error("output on while deselected");
    a_hw_on: assert property ((!WP_N && STATUS_BYTE[7])[*4] |-> HW_PROTECT) else $error("hw protect off");
    a_hw_pin_hi: assert property (WP_N[*4] |-> !HW_PROTECT) else $error("hw protect with pin high");
    a_hw_en_lo: assert property ((!STATUS_BYTE[7])[*4] |-> !HW_PROTECT) else $error("pin not ignored");
    a_arr_framed: assert property (ARRAY_WR_STB |-> $past(CS_N, 2)) else $error("write before deselect");
    a_arr_prot: assert property (ARRAY_WR_STB |-> !qtr_locked) else $error("protected quarter written");
    a_arr_busy: assert property (ARRAY_WR_STB |-> ##[0:4] STATUS_BYTE[0]) else $error("no busy flag");
    a_nv_latch: assert property (NV_STORE_STB |-> ##[1:3] s_settled) else $error("latch kept after store");
    a_nv_shown: assert property (NV_STORE_STB |-> ##[1:3] s_shown) else $error("stored bits not shown");
    a_busy_len: assert property ($fell(STATUS_BYTE[0]) |-> busy_cnt_r >= TWC_CYCLES - 2
        && busy_cnt_r <= TWC_CYCLES + 4) else $error("write cycle length");
endmodule // sep_props
bind sep_protect_ctl sep_props #(.TWC_CYCLES(TWC_CYCLES)) sep_props_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N), .NV_LOAD_BITS(NV_LOAD_BITS), .SO(SO),
    .SO_OE(SO_OE), .STATUS_BYTE(STATUS_BYTE), .HW_PROTECT(HW_PROTECT), .ARRAY_WR_STB(ARRAY_WR_STB),
    .ARRAY_WR_ADDR(ARRAY_WR_ADDR), .ARRAY_WR_LEN(ARRAY_WR_LEN), .NV_STORE_STB(NV_STORE_STB),
    .NV_STORE_BITS(NV_STORE_BITS));

// ---- bench/sep_spi_master.sv ----
// link master model framing transfers for the protection block
`timescale 1ns/1ns
module sep_spi_master (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    localparam int HALF = 24; // half of the 48 ns link period
    // idle: clock parked low, deselected, pause released
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // n bits of d from the top, pause before bit hp; undriven output reads as pulled high
    task automatic xfer(input logic [31:0] d, input int n, input int hp, output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        #(2 * HALF);
        for (int i = 0; i < n; i++) begin
            if (i == hp) begin
                hold_n = 1'b0;
                // wiggles a paused device must not count
                repeat (2) begin
                    #HALF si = ~si;
                    sck = 1'b1;
                    #HALF sck = 1'b0;
                end
                #HALF hold_n = 1'b1;
            end
            si = d[31 - (i % 32)]; // word repeats past 32 bits
            #HALF sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'b1};
            #HALF sck = 1'b0;
        end
        // clock idles before deselect; released data line loses its last bit
        #(2 * HALF) si = ~si;
        cs_n = 1'b1;
        #(4 * HALF);
    endtask
endmodule // sep_spi_master

// ---- bench/tb.sv ----
// testbench for the eeprom protection and pause block
`timescale 1ns/1ns
`define CK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    localparam int TWC = 500; // shortened write cycle keeps the run brief
    logic mclk = 1'b0;
    logic sys_rst, wp_n, so, so_oe, hw_prot, arr_stb, nv_stb, sck, cs_n, si, hold_n;
    logic [7:0] status_byte, arr_len, rxb;
    logic [14:0] arr_addr;
    sep_pkg::sep_nv_s nv_load, nv_bits;
    int n_fail = 0, checks = 0, n_arr = 0, n_nv = 0, a, p, pe;
    always #5 mclk = ~mclk;
    sep_protect_ctl #(.TWC_CYCLES(TWC)) sep_protect_ctl_i (.MCLK(mclk), .SYS_RST(sys_rst), .SCK(sck),
        .CS_N(cs_n), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n), .NV_LOAD_BITS(nv_load), .SO(so), .SO_OE(so_oe),
        .STATUS_BYTE(status_byte), .HW_PROTECT(hw_prot), .ARRAY_WR_STB(arr_stb), .ARRAY_WR_ADDR(arr_addr),
        .ARRAY_WR_LEN(arr_len), .NV_STORE_STB(nv_stb), .NV_STORE_BITS(nv_bits));
    sep_spi_master sep_spi_master_i (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
    // count write strobes of both kinds
    always @(posedge mclk) begin
        n_arr += (arr_stb === 1'b1);
        n_nv += (nv_stb === 1'b1);
    end
    // wait whole clocks, then let the edge settle
    task automatic wc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic frm(input logic [31:0] d, input int n, input int hp);
        sep_spi_master_i.xfer(d, n, hp, rxb);
        wc(8);
    endtask
    task automatic sw(input logic [7:0] v);
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        frm({sep_pkg::OP_STATUS_WRITE, v, 16'h0}, 16, -1);
        wc(TWC + 10);
    endtask
    task automatic aw(input logic [1:0] q);
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        frm({sep_pkg::OP_ARRAY_WRITE, 1'b0, q, 13'h0, 8'ha5}, 32, -1);
        wc(TWC + 10);
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // cut a hung run short
    initial begin
        #900000;
        n_fail++;
        close_out();
    end
    initial begin
        sys_rst = 1'b1;
        wp_n = 1'b1;
        nv_load = 3'b001;
        wc(5);
        `CK("oe_rst", 1'b0, so_oe)
        @(posedge mclk) sys_rst <= 1'b0;
        wc(6);
        `CK("st_pwr", 8'h04, status_byte)
        a = n_arr;
        frm({sep_pkg::OP_ARRAY_WRITE, 16'h0, 8'h5a}, 32, -1);
        wc(TWC);
        `CK("no_latch", a, n_arr)
        frm({sep_pkg::OP_STATUS_READ, 24'h0}, 16, -1);
        `CK("rd_st", 8'h04, rxb)
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        frm({sep_pkg::OP_STATUS_READ, 24'h0}, 16, 3);
        `CK("rd_pause", 8'h06, rxb)
        frm({sep_pkg::OP_LATCH_CLEAR, 24'h0}, 8, -1);
        `CK("wel_clr", 8'h04, status_byte)
        // every protection level against every quarter
        for (int b = 0; b < 4; b++) begin
            sw({4'h7, b[1:0], 2'h0});
            `CK("nv", {1'b0, b[1:0]}, nv_bits)
            `CK("st", {4'h0, b[1:0], 2'h0}, status_byte)
            for (int q = 0; q < 4; q++) begin
                a = n_arr;
                aw(q[1:0]);
                pe = (b == 3) || (b == 2 && q >= 2) || (b == 1 && q == 3);
                `CK("arr_wr", a + 1 - pe, n_arr)
                if (pe == 0) begin
                    `CK("arr_addr", {q[1:0], 13'h0}, arr_addr)
                    `CK("arr_len", 8'h01, arr_len)
                end
            end
        end
        sw(8'h80);
        @(posedge mclk) wp_n <= 1'b0;
        wc(6);
        `CK("hw_on", 1'b1, hw_prot)
        p = n_nv;
        sw(8'h8c);
        `CK("hw_block", p, n_nv)
        `CK("hw_st", 8'h82, status_byte)
        a = n_arr;
        aw(2'h2);
        `CK("hw_arr", a + 1, n_arr)
        @(posedge mclk) wp_n <= 1'b1;
        wc(6);
        `CK("hw_off", 1'b0, hw_prot)
        sw(8'h00);
        @(posedge mclk) wp_n <= 1'b0;
        sw(8'h08);
        `CK("pin_ign", 8'h08, status_byte)
        // two data bytes make a short page write
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        frm({sep_pkg::OP_ARRAY_WRITE, 24'h0}, 40, -1);
        wc(TWC + 10);
        `CK("pg_len", 8'h02, arr_len)
        // frames one bit short must be discarded
        p = n_nv;
        a = n_arr;
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        frm({sep_pkg::OP_STATUS_WRITE, 24'h0}, 15, -1);
        frm({sep_pkg::OP_ARRAY_WRITE, 24'h0}, 31, -1);
        wc(TWC);
        `CK("short_sw", p, n_nv)
        `CK("short_aw", a, n_arr)
        `CK("st_keep", 8'h0a, status_byte)
        // status read and array write while the cycle runs
        frm({sep_pkg::OP_STATUS_WRITE, 24'h0}, 16, -1);
        frm({sep_pkg::OP_STATUS_READ, 24'h0}, 16, -1);
        `CK("rd_busy", 8'h0b, rxb)
        frm({sep_pkg::OP_ARRAY_WRITE, 24'h0}, 32, -1);
        frm({sep_pkg::OP_LATCH_SET, 24'h0}, 8, -1);
        wc(TWC);
        // a select pulse with no clocks must not replay the latch set
        frm(32'h0, 0, -1);
        `CK("no_replay", 1'b0, status_byte[1])
        `CK("busy_arr", a, n_arr)
        `CK("st_done", 8'h00, status_byte)
        close_out();
    end
endmodule // tb

// ---- rtl/sep_pkg.sv ----
// constants, types and helpers for the serial eeprom protection and pause logic
package sep_pkg;

    // instruction codes
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;

    // status byte field positions
    localparam int SR_PIN_EN_BIT = 7;
    localparam int SR_BP_HI_BIT = 3;
    localparam int SR_BP_LO_BIT = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_WIP_BIT = 0;

    // frame bit counts
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
    localparam logic [CNT_W-1:0] CMD_BITS = 10'h008;
    localparam logic [CNT_W-1:0] BYTE1_BITS = 10'h010;
    localparam logic [CNT_W-1:0] ADDR_BITS = 10'h018;
    localparam logic [CNT_W-1:0] MIN_ARRAY_WR_BITS = 10'h020;
    localparam int BYTE_IDX_W = 3;
    localparam logic [BYTE_IDX_W-1:0] BYTE_ALIGNED = 3'h0;
    localparam logic [7:0] PAGE_BYTES = 8'h40;

    // address field: bit 15 is ignored, bits 14:13 pick the protection quarter
    localparam int ADDR_W = 15;
    localparam int QTR_HI_IN_BYTE1 = 6;
    localparam int QTR_LO_IN_BYTE1 = 5;

    // block protect encodings
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] QTR_TOP = 2'h3;

    // nonvolatile reset default before restore
    localparam logic [1:0] BP_RESET = 2'h0;

    // self-timed write cycle
    localparam int MCLK_MHZ = 100;
    localparam int TWC_US = 5000;
    localparam int TWC_CYCLES = TWC_US * MCLK_MHZ;

    typedef struct packed {
        logic pin_en;
        logic [1:0] bp;
    } sep_nv_s;

    typedef enum logic {
        ST_IDLE,
        ST_WRITE
    } sep_state_e;

    // true when the quarter of the array holding the address is protected
    function automatic logic sep_is_protected(input logic [1:0] bp, input logic [1:0] qtr);
        logic prot;
        prot = 1'b0;
        unique case (bp)
            BP_NONE: prot = 1'b0;
            BP_QUARTER: prot = (qtr == QTR_TOP);
            BP_HALF: prot = qtr[1];
            BP_ALL: prot = 1'b1;
        endcase
        return prot;
    endfunction

    // assemble the readable status byte, unused bits read zero
    function automatic logic [7:0] sep_status_byte(input sep_nv_s nv, input logic write_enable_latch, input logic write_in_progress);
        logic [7:0] b;
        b = 8'h00;
        b[SR_PIN_EN_BIT] = nv.pin_en;
        b[SR_BP_HI_BIT] = nv.bp[1];
        b[SR_BP_LO_BIT] = nv.bp[0];
        b[SR_WEL_BIT] = write_enable_latch;
        b[SR_WIP_BIT] = write_in_progress;
        return b;
    endfunction

endpackage

// ---- rtl/sep_protect_ctl.sv ----
// serial eeprom write protection, chip select framing and pause control
// Summary of operation
// - block protect bits pick protected quarter; protected array writes are never done
// - status write command updates pin enable and block protect nonvolatile bits
// - hardware protection active exactly when protect pin low and pin enable set
// - hardware protection blocks only status writes, array writes still proceed
// - latch clear refuses all array and status writes; latch set command sets it
// - latch clears once byte, page or status write completes
// - valid status write starts self-timed cycle on chip select rising edge
// - internal write starts only after exact bit count, otherwise discarded
// - array and status writes during internal write are ignored, programming continues
// - power-on standby, latch clear, output off, active only after select falls
// - deselect mid-cycle lets the programming cycle finish, then standby
// - deselected device releases serial output
// - serial input sampled on every rising serial clock edge while selected and not paused
// - serial output changes after falling serial clock edge
// - pin enable set and pin low during sequence cancels status write
// - pin enable clear ignores the protect pin completely
// - pause input low freezes the sequence without resetting it
// - pause entry takes effect at once, whatever the serial clock level
// - while paused, serial pins are ignored and output released
// - resume as soon as pause is raised, whatever the serial clock level
// - lowering the pause input releases serial output at once
// - status byte: pin enable 7, protect high 3, protect low 2, latch 1, busy 0
// - busy bit reads one during internal write, zero otherwise, read-only
// - status readable at any time, also during internal write
// - all bytes move most significant bit first
`timescale 1ns/1ns
module sep_protect_ctl #(
    parameter int TWC_CYCLES = sep_pkg::TWC_CYCLES,
    parameter int TMR_W = $clog2(TWC_CYCLES + 1)
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic HOLD_N,
    input wire logic WP_N,
    input wire sep_pkg::sep_nv_s NV_LOAD_BITS,
    output logic SO,
    output logic SO_OE,
    output logic [7:0] STATUS_BYTE,
    output logic HW_PROTECT,
    output logic ARRAY_WR_STB,
    output logic [sep_pkg::ADDR_W-1:0] ARRAY_WR_ADDR,
    output logic [7:0] ARRAY_WR_LEN,
    output logic NV_STORE_STB,
    output sep_pkg::sep_nv_s NV_STORE_BITS
);

    // ---------------- serial clock domain ----------------
    logic fresh_r;
    logic [sep_pkg::CNT_W-1:0] cnt_r;
    logic [sep_pkg::CNT_W-1:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [7:0] opcode_r;
    logic [7:0] byte1_r;
    logic [7:0] byte2_r;
    logic [7:0] st_s1_r;
    logic [7:0] st_s2_r;
    logic so_clr;
    logic sck_rst;
    logic bit_tog_r;

    // a new frame restarts the count at its first clock; held from deselect until then
    assign sck_rst = SYS_RST | CS_N;

    // shift and count, frozen while paused
    always_comb begin
        sh_nxt = {sh_r[6:0], SI};
        cnt_nxt = cnt_r;
        if (fresh_r) begin
            sh_nxt = {7'h00, SI};
            cnt_nxt = {{(sep_pkg::CNT_W-1){1'b0}}, 1'b1};
        end else if (cnt_r != sep_pkg::CNT_MAX) begin
            cnt_nxt = cnt_r + {{(sep_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // fresh flag: set by deselect, dropped at first sampled bit
    always_ff @(posedge SCK or posedge sck_rst) begin
        if (sck_rst) begin
            fresh_r <= 1'b1;
        end else if (HOLD_N) begin
            fresh_r <= 1'b0;
        end
    end

    // first-bit toggle: flips once per frame that carries at least one clock
    // a toggle rather than a pulse, since the serial clock may stop right after it
    always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bit_tog_r <= 1'b0;
        end else if (fresh_r && HOLD_N && !CS_N) begin
            bit_tog_r <= ~bit_tog_r;
        end
    end

    // input sampling keeps its content after deselect so the system side can judge the frame
    always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cnt_r <= '0;
            sh_r <= 8'h00;
            opcode_r <= 8'h00;
            byte1_r <= 8'h00;
            byte2_r <= 8'h00;
        end else if (HOLD_N && !CS_N) begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            if (cnt_nxt == sep_pkg::CMD_BITS) begin
                opcode_r <= sh_nxt;
            end
            if (cnt_nxt == sep_pkg::BYTE1_BITS) begin
                byte1_r <= sh_nxt;
            end
            if (cnt_nxt == sep_pkg::ADDR_BITS) begin
                byte2_r <= sh_nxt;
            end
        end
    end

    // status byte crosses as independent level bits, two stages
    always_ff @(negedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_s1_r <= 8'h00;
            st_s2_r <= 8'h00;
        end else begin
            st_s1_r <= STATUS_BYTE;
            st_s2_r <= st_s1_r;
        end
    end

    // output release is asynchronous: deselect or pause drops the enable without a clock
    assign so_clr = SYS_RST | CS_N | ~HOLD_N;

    // status read drives one bit per falling edge, repeating the byte
    always_ff @(negedge SCK or posedge so_clr) begin
        if (so_clr) begin
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end else if (!fresh_r && opcode_r == sep_pkg::OP_STATUS_READ && cnt_r >= sep_pkg::CMD_BITS) begin
            SO <= st_s2_r[~cnt_r[sep_pkg::BYTE_IDX_W-1:0]];
            SO_OE <= 1'b1;
        end else begin
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end
    end

    // ---------------- system clock domain ----------------
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic wp_s1_r;
    logic wp_s2_r;
    logic armed_r;
    logic in_frame_r;
    logic wp_low_seen_r;
    logic restore_r;
    sep_pkg::sep_nv_s nv_r;
    sep_pkg::sep_nv_s nv_pend_r;
    logic wel_r;
    logic wr_status_r;
    sep_pkg::sep_state_e state_r;
    logic [TMR_W-1:0] tmr_r;
    logic cs_fall;
    logic cs_rise;
    logic frame_end;
    logic hw_prot;
    logic wp_low_any;
    logic is_latch_set;
    logic is_latch_clr;
    logic sw_req;
    logic aw_req;
    logic aw_prot;
    logic wc_done;
    logic [7:0] raw_len;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic got_bits_r;
    logic tog_edge;

    // two-stage synchronisers for the select and protect pins
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= CS_N;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            wp_s1_r <= WP_N;
            wp_s2_r <= wp_s1_r;
        end
    end

    // the frame toggle crosses as one bit through two stages
    // the third stage only serves to find its edge
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= bit_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // one cycle per frame that was clocked
    assign tog_edge = tog_s2_r ^ tog_s3_r;

    assign cs_fall = cs_s3_r & ~cs_s2_r;
    assign cs_rise = ~cs_s3_r & cs_s2_r;
    // frame words are stable here: the serial clock stops before select rises
    // a select pulse without clocks leaves old words behind, so it is not judged
    assign frame_end = cs_rise & in_frame_r & got_bits_r;

    assign hw_prot = nv_r.pin_en & ~wp_s2_r;
    assign wp_low_any = wp_low_seen_r | ~wp_s2_r;
    assign wc_done = (state_r == sep_pkg::ST_WRITE) && (tmr_r == '0);
    assign raw_len = 8'((cnt_r - sep_pkg::ADDR_BITS) >> sep_pkg::BYTE_IDX_W);
    assign aw_prot = sep_pkg::sep_is_protected(nv_r.bp,
        {byte1_r[sep_pkg::QTR_HI_IN_BYTE1], byte1_r[sep_pkg::QTR_LO_IN_BYTE1]});

    // decode of a finished frame
    always_comb begin
        is_latch_set = frame_end && opcode_r == sep_pkg::OP_LATCH_SET && cnt_r == sep_pkg::CMD_BITS;
        is_latch_clr = frame_end && opcode_r == sep_pkg::OP_LATCH_CLEAR && cnt_r == sep_pkg::CMD_BITS;
        sw_req = frame_end && opcode_r == sep_pkg::OP_STATUS_WRITE
            && cnt_r == sep_pkg::BYTE1_BITS
            && wel_r
            && state_r == sep_pkg::ST_IDLE
            && !(nv_r.pin_en && wp_low_any);
        aw_req = frame_end && opcode_r == sep_pkg::OP_ARRAY_WRITE
            && cnt_r >= sep_pkg::MIN_ARRAY_WR_BITS
            && cnt_r[sep_pkg::BYTE_IDX_W-1:0] == sep_pkg::BYTE_ALIGNED
            && wel_r
            && state_r == sep_pkg::ST_IDLE
            && !aw_prot;
    end

    // frame tracking: only a falling select seen after a high one opens a frame
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            armed_r <= 1'b0;
            in_frame_r <= 1'b0;
            wp_low_seen_r <= 1'b0;
        end else begin
            if (cs_s2_r) begin
                armed_r <= 1'b1;
            end
            if (cs_fall && armed_r) begin
                in_frame_r <= 1'b1;
                wp_low_seen_r <= ~wp_s2_r;
            end else if (cs_rise) begin
                in_frame_r <= 1'b0;
                wp_low_seen_r <= 1'b0;
            end else if (in_frame_r && !wp_s2_r) begin
                wp_low_seen_r <= 1'b1;
            end
        end
    end

    // clocked-frame flag: cleared when a frame opens, set by its first bit
    // a toggle edge landing in the opening cycle still counts, so the set wins
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            got_bits_r <= 1'b0;
        end else if (cs_fall) begin
            got_bits_r <= tog_edge;
        end else if (tog_edge) begin
            got_bits_r <= 1'b1;
        end
    end

    // write enable latch: a set in the same cycle as a clear wins
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wel_r <= 1'b0;
        end else if (is_latch_set) begin
            wel_r <= 1'b1;
        end else if (is_latch_clr || wc_done) begin
            wel_r <= 1'b0;
        end
    end

    // self-timed write cycle; runs on regardless of select
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= sep_pkg::ST_IDLE;
            tmr_r <= '0;
            wr_status_r <= 1'b0;
            nv_pend_r <= '0;
        end else begin
            unique case (state_r)
                sep_pkg::ST_IDLE: begin
                    if (sw_req || aw_req) begin
                        state_r <= sep_pkg::ST_WRITE;
                        tmr_r <= TMR_W'(TWC_CYCLES - 1);
                        wr_status_r <= sw_req;
                        nv_pend_r.pin_en <= byte1_r[sep_pkg::SR_PIN_EN_BIT];
                        nv_pend_r.bp <= {byte1_r[sep_pkg::SR_BP_HI_BIT], byte1_r[sep_pkg::SR_BP_LO_BIT]};
                    end
                end
                sep_pkg::ST_WRITE: begin
                    if (wc_done) begin
                        state_r <= sep_pkg::ST_IDLE;
                    end else begin
                        tmr_r <= tmr_r - {{(TMR_W-1){1'b0}}, 1'b1};
                    end
                end
            endcase
        end
    end

    // nonvolatile bits: restored once after reset, committed at end of a status write
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            restore_r <= 1'b1;
            nv_r.pin_en <= 1'b0;
            nv_r.bp <= sep_pkg::BP_RESET;
            NV_STORE_STB <= 1'b0;
            NV_STORE_BITS <= '0;
        end else begin
            restore_r <= 1'b0;
            NV_STORE_STB <= 1'b0;
            if (restore_r) begin
                nv_r <= NV_LOAD_BITS;
            end else if (wc_done && wr_status_r) begin
                nv_r <= nv_pend_r;
                NV_STORE_STB <= 1'b1;
                NV_STORE_BITS <= nv_pend_r;
            end
        end
    end

    // array commit strobe with start address and byte count
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ARRAY_WR_STB <= 1'b0;
            ARRAY_WR_ADDR <= '0;
            ARRAY_WR_LEN <= 8'h00;
        end else begin
            ARRAY_WR_STB <= aw_req;
            if (aw_req) begin
                ARRAY_WR_ADDR <= {byte1_r[sep_pkg::ADDR_W-9:0], byte2_r};
                // page data wraps, so no more than one page of bytes is kept
                ARRAY_WR_LEN <= (raw_len > sep_pkg::PAGE_BYTES) ? sep_pkg::PAGE_BYTES : raw_len;
            end
        end
    end

    // visible status, also the source the serial side reads back
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            STATUS_BYTE <= 8'h00;
            HW_PROTECT <= 1'b0;
        end else begin
            STATUS_BYTE <= sep_pkg::sep_status_byte(nv_r, wel_r, state_r == sep_pkg::ST_WRITE);
            HW_PROTECT <= hw_prot;
        end
    end

endmodule // sep_protect_ctl
